// ---- rtl/pps_pager.sv ----
`timescale 1ns/1ps
module pps_pager
   import pps_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Status
   input wire logic operative_i,
   output logic busy_o,
   output logic [ADDR_W-1:0] fetch_ptr_o,
   output logic [ADDR_W-1:0] store_ptr_o,
   // Pager bus to control memory
   output pps_mem_req_t mem_o,
   input wire logic mem_ack_i,
   input wire logic [DATA_W-1:0] mem_rdata_i,
   // Function-code logic
   output pps_fc_req_t fc_o,
   input wire pps_fc_acc_t acc_i,
   input wire logic acc_sense_i,
   output logic acc_sense_o,
   // Page port switches
   input wire logic sw_valid_i,
   input wire logic [1:0] sw_page_i,
   input wire pps_bus_t sw_bus_i,
   output pps_page_map_t page_bus_o
);
   pps_state_t state_r, state_nxt;
   logic busy_r, busy_nxt;
   logic [ADDR_W-1:0] fp_r, fp_nxt;
   logic [ADDR_W-1:0] sp_r, sp_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [DATA_W-1:0] ir_r, ir_nxt;
   logic [DATA_W-1:0] buf_r, buf_nxt;
   logic pend_r, pend_nxt;
   logic [ADDR_W-1:0] pend_addr_r, pend_addr_nxt;
   pps_mem_req_t mem_r, mem_nxt;
   pps_fc_req_t fc_r, fc_nxt;
   logic sense_r, sense_nxt;
   pps_page_map_t page_r, page_nxt;

   pps_instr_t ins;
   logic acc_is_state;
   logic acc_is_lget;

   pps_dec u_dec (
      .instr_i(ir_r),
      .ins_o(ins),
      .code_i(acc_i.code),
      .is_state_o(acc_is_state),
      .is_lget_o(acc_is_lget)
   );

   // Sequencing steps only at word boundaries, never inside a memory access
   wire boundary = (state_r == ST_FETCH) || (state_r == ST_EXEC) || (state_r == ST_RD) ||
                   (state_r == ST_WR) || (state_r == ST_FC);
   wire run = busy_r && !pend_r;
   wire own_grant = acc_i.valid && acc_i.own && (state_r == ST_FC);
   wire acc_pager = acc_i.valid && (acc_is_state || acc_is_lget);
   wire other_hit = acc_pager && !acc_i.own && (state_r == ST_FC);
   wire state_hit = acc_i.valid && acc_is_state;
   wire lget_hit = acc_i.valid && acc_is_lget && operative_i;
   wire pend_apply = pend_r && boundary;
   wire state_sense = busy_r ? acc_i.code[ST_SENSE_BUSY] : acc_i.code[ST_SENSE_OFF];
   wire state_new = busy_r ? acc_i.code[ST_NEW_BUSY] : acc_i.code[ST_NEW_OFF];
   wire fc_sense = acc_is_state ? state_sense : (acc_is_lget ? 1'b0 : acc_sense_i);
   wire page_ok = sw_valid_i && (sw_page_i != PAGE_BAD);
   wire [ADDR_W-1:0] fp_inc = fp_r + 16'h0001;
   wire [ADDR_W-1:0] sp_inc = sp_r + 16'h0001;
   // Fetch already stepped past the code word, so a set sense bit adds the skip
   wire [ADDR_W-1:0] fp_sense = fp_r + {15'h0000, fc_sense};

   always_comb begin
      state_nxt = state_r;
      fp_nxt = fp_r;
      sp_nxt = sp_r;
      cnt_nxt = cnt_r;
      ir_nxt = ir_r;
      buf_nxt = buf_r;
      mem_nxt = mem_r;
      fc_nxt = fc_r;
      if (mem_r.req && mem_ack_i) begin
         mem_nxt.req = 1'b0;
         mem_nxt.we = 1'b0;
      end
      unique case (state_r)
         ST_FETCH: begin
            if (run) begin
               mem_nxt.req = 1'b1;
               mem_nxt.we = 1'b0;
               mem_nxt.addr = fp_r;
               state_nxt = ST_FWAIT;
            end
         end
         ST_FWAIT: begin
            if (mem_ack_i) begin
               ir_nxt = mem_rdata_i;
               fp_nxt = fp_inc;
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (run) begin
               unique case (ins.kind)
                  TYP_FC: begin
                     fc_nxt.req = 1'b1;
                     fc_nxt.code = ins.code;
                     state_nxt = ST_FC;
                  end
                  TYP_LDPUT: begin
                     sp_nxt = ins.addr;
                     state_nxt = ST_FETCH;
                  end
                  TYP_MOVE: begin
                     cnt_nxt = ins.cnt;
                     state_nxt = ST_RD;
                  end
                  TYP_LDMOVE: begin
                     sp_nxt = ins.addr;
                     cnt_nxt = ins.cnt;
                     state_nxt = ST_RD;
                  end
               endcase
            end
         end
         ST_RD: begin
            if (run) begin
               if (cnt_r == RST_CNT) begin
                  state_nxt = ST_FETCH;
               end else begin
                  mem_nxt.req = 1'b1;
                  mem_nxt.we = 1'b0;
                  mem_nxt.addr = fp_r;
                  state_nxt = ST_RDW;
               end
            end
         end
         ST_RDW: begin
            if (mem_ack_i) begin
               buf_nxt = mem_rdata_i;
               fp_nxt = fp_inc;
               state_nxt = ST_WR;
            end
         end
         ST_WR: begin
            if (run) begin
               mem_nxt.req = 1'b1;
               mem_nxt.we = 1'b1;
               mem_nxt.addr = sp_r;
               mem_nxt.wdata = buf_r;
               state_nxt = ST_WRW;
            end
         end
         ST_WRW: begin
            if (mem_ack_i) begin
               sp_nxt = sp_inc;
               cnt_nxt = cnt_r - 14'h0001;
               state_nxt = ST_RD;
            end
         end
         ST_FC: begin
            if (own_grant) begin
               fc_nxt.req = 1'b0;
               fp_nxt = fp_sense;
               state_nxt = ST_FETCH;
            end else if (other_hit) begin
               fc_nxt.req = 1'b0;
               state_nxt = ST_FETCH;
            end
         end
      endcase
      // A pending load-fetch overrides the step at the next word boundary
      if (pend_apply) begin
         fp_nxt = pend_addr_r;
         cnt_nxt = RST_CNT;
         fc_nxt.req = 1'b0;
         state_nxt = ST_FETCH;
      end
   end

   always_comb begin
      pend_nxt = pend_r;
      pend_addr_nxt = pend_addr_r;
      busy_nxt = busy_r;
      sense_nxt = sense_r;
      if (pend_apply) begin
         pend_nxt = 1'b0;
         busy_nxt = 1'b1;
      end
      if (lget_hit) begin
         pend_nxt = 1'b1;
         pend_addr_nxt = acc_i.code[ADDR_HI:ADDR_LO];
      end
      if (state_hit) begin
         busy_nxt = state_new && (busy_r || operative_i);
      end
      if (acc_pager) begin
         sense_nxt = acc_is_state ? state_sense : 1'b0;
      end
      page_nxt = page_r;
      if (page_ok) begin
         page_nxt[sw_page_i] = sw_bus_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_r <= ST_FETCH;
         busy_r <= 1'b0;
         fp_r <= RST_FP;
         sp_r <= RST_SP;
         cnt_r <= RST_CNT;
         ir_r <= '0;
         buf_r <= '0;
         pend_r <= 1'b0;
         pend_addr_r <= RST_FP;
         mem_r <= '0;
         fc_r <= '0;
         sense_r <= 1'b0;
         page_r <= '{NPAGES{RST_BUS}};
      end else if (ce_i) begin
         state_r <= state_nxt;
         busy_r <= busy_nxt;
         fp_r <= fp_nxt;
         sp_r <= sp_nxt;
         cnt_r <= cnt_nxt;
         ir_r <= ir_nxt;
         buf_r <= buf_nxt;
         pend_r <= pend_nxt;
         pend_addr_r <= pend_addr_nxt;
         mem_r <= mem_nxt;
         fc_r <= fc_nxt;
         sense_r <= sense_nxt;
         page_r <= page_nxt;
      end
   end

   assign busy_o = busy_r;
   assign fetch_ptr_o = fp_r;
   assign store_ptr_o = sp_r;
   assign mem_o = mem_r;
   assign fc_o = fc_r;
   assign acc_sense_o = sense_r;
   assign page_bus_o = page_r;

   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);

   a_fetch_step: assert property (
      (ce_i && state_r == ST_FWAIT && mem_ack_i && !pend_r)
      |=> (fp_r == 16'($past(fp_r) + 16'h0001)) && (state_r == ST_EXEC) && !mem_r.req)
      else $error("fetch pointer did not step after fetch");

   a_issue_code: assert property (
      (ce_i && run && state_r == ST_EXEC && ir_r[TYPE_HI:TYPE_LO] == TYP_FC)
      |=> fc_r.req && (fc_r.code == $past(ir_r[FC_HI:FC_LO])) && (state_r == ST_FC))
      else $error("type 00 did not issue its function code");

   a_load_store: assert property (
      (ce_i && run && state_r == ST_EXEC && ir_r[TYPE_HI:TYPE_LO] == TYP_LDPUT)
      |=> (sp_r == $past(ir_r[ADDR_HI:ADDR_LO])) && (state_r == ST_FETCH))
      else $error("load-store did not load the store pointer");

   a_move_count: assert property (
      (ce_i && run && state_r == ST_EXEC && ir_r[TYPE_HI:TYPE_LO] == TYP_MOVE)
      |=> (cnt_r == $past(ir_r[CNT_HI:CNT_LO])) && (sp_r == $past(sp_r)) && (state_r == ST_RD))
      else $error("move did not take its 14-bit count");

   a_load_move: assert property (
      (ce_i && run && state_r == ST_EXEC && ir_r[TYPE_HI:TYPE_LO] == TYP_LDMOVE)
      |=> (sp_r == $past(ir_r[ADDR_HI:ADDR_LO])) && (cnt_r == $past(ir_r[CNT_HI:CNT_LO])))
      else $error("combined load-and-move wrong");

   a_source_read: assert property (
      (ce_i && run && state_r == ST_RD && cnt_r != RST_CNT)
      |=> mem_r.req && !mem_r.we && (mem_r.addr == fp_r) && (fp_r == $past(fp_r)))
      else $error("source word not read at fetch pointer");

   a_dest_write: assert property (
      (ce_i && run && state_r == ST_WR)
      |=> mem_r.req && mem_r.we && (mem_r.addr == $past(sp_r)) && (mem_r.wdata == $past(buf_r)))
      else $error("word not written at store pointer");

   a_move_advance: assert property (
      (ce_i && state_r == ST_WRW && mem_ack_i)
      |=> (sp_r == 16'($past(sp_r) + 16'h0001)) && (cnt_r == 14'($past(cnt_r) - 14'h0001)))
      else $error("store pointer or count did not advance");

   a_move_end: assert property (
      (ce_i && run && state_r == ST_RD && cnt_r == RST_CNT)
      |=> (state_r == ST_FETCH) && (fp_r == $past(fp_r)) && (sp_r == $past(sp_r)))
      else $error("move end did not resume fetching after source");

   a_sense_skip: assert property (
      (ce_i && own_grant && !acc_is_lget && !pend_r)
      |=> (fp_r == 16'($past(fp_r) + {15'h0000, $past(fc_sense)})) && !fc_r.req)
      else $error("sense bit did not set fetch step");

   a_other_drop: assert property (
      (ce_i && other_hit) |=> !fc_r.req && (fp_r == $past(fp_r)) ##1 !fc_r.req)
      else $error("own code not dropped after other pager code");

   a_code_hold: assert property (
      (ce_i && fc_r.req && !own_grant && !other_hit && !pend_apply)
      |=> fc_r.req && $stable(fc_r.code))
      else $error("function code request changed before acceptance");

   a_branch_keep: assert property (
      (ce_i && own_grant && acc_is_lget && operative_i)
      |=> pend_r && (sp_r == $past(sp_r)) && (pend_addr_r == $past(acc_i.code[ADDR_HI:ADDR_LO])))
      else $error("branch disturbed store pointer or lost target");

   a_redirect: assert property (
      (ce_i && pend_apply && !state_hit && !lget_hit)
      |=> busy_r && (fp_r == $past(pend_addr_r)) && (cnt_r == RST_CNT) && (state_r == ST_FETCH))
      else $error("load-fetch redirect incomplete");

   a_stop: assert property (
      (ce_i && state_hit && !state_new)
      |=> !busy_r ##1 (!busy_r || $past(pend_r || lget_hit || state_hit)))
      else $error("stop code did not halt the pager");

   a_halt_skip: assert property (
      (ce_i && own_grant && acc_is_state && busy_r && acc_i.code[ST_SENSE_BUSY] &&
       !acc_i.code[ST_NEW_BUSY] && !pend_r)
      |=> !busy_r && (fp_r == 16'($past(fp_r) + 16'h0001)))
      else $error("halt-and-skip pointer wrong");

   a_skip: assert property (
      (ce_i && own_grant && acc_is_state && busy_r && acc_i.code[ST_SENSE_BUSY] &&
       acc_i.code[ST_NEW_BUSY] && !pend_r)
      |=> busy_r && (fp_r == 16'($past(fp_r) + 16'h0001)))
      else $error("skip did not pass next instruction");

   a_page_switch: assert property (
      (ce_i && page_ok) |=> page_r[$past(sw_page_i)] == $past(sw_bus_i))
      else $error("page switch not applied");

   c_move_write: cover property (ce_i && state_r == ST_WRW && mem_ack_i);
   c_skip: cover property (ce_i && own_grant && fc_sense);
   c_redirect: cover property (ce_i && pend_apply);
   c_halt: cover property (ce_i && own_grant && acc_is_state && !state_new);
endmodule

// ---- rtl/pps_pkg.sv ----
// Contract
// - One 32-bit word; top two bits give type
// - Fetch pointer steps by one per instruction
// - Accepted load-fetch code starts the pager; the code ignores it while operative_i is low
// - Source words follow move; fetch resumes after
// - Load-store instruction copies address into store pointer
// - Move writes from store pointer, consecutive locations
// - After move both pointers point past blocks
// - Move word count field is 14 bits
// - Combined form loads store pointer, then moves
// - Issue code; sense one skips, zero steps
// - Other accepted pager code drops own code
// - Branch loads fetch pointer, store pointer untouched
// - Halt-and-skip stops, fetch pointer two past
// - Skip passes over the next instruction
// - Halt stops, fetch pointer just past
// - Any accepted load-fetch code redirects fetching while operative
// - Any accepted stop code halts the pager
// - Codes are 19 bits, one at a time
// - Each page switched to exactly one bus
// - Two states, off and busy, sensed and set
// - Load-fetch when operative clears count, becomes busy
package pps_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 16;
   localparam int CNT_W = 14;
   localparam int FC_W = 19;
   localparam int NPAGES = 3;

   // Instruction field positions, bit 31 of the word being its msb
   localparam int TYPE_HI = 31;
   localparam int TYPE_LO = 30;
   localparam int CNT_HI = 29;
   localparam int CNT_LO = 16;
   localparam int ADDR_HI = 15;
   localparam int ADDR_LO = 0;
   localparam int FC_HI = 18;
   localparam int FC_LO = 0;

   // Instruction types
   localparam logic [1:0] TYP_FC = 2'h0;
   localparam logic [1:0] TYP_LDPUT = 2'h1;
   localparam logic [1:0] TYP_MOVE = 2'h2;
   localparam logic [1:0] TYP_LDMOVE = 2'h3;

   // Function codes that act on the pager
   localparam logic [14:0] FC_STATE_TAG = 15'h0800;
   localparam int FC_STATE_TAG_LO = 4;
   localparam logic [2:0] FC_LGET_TAG = 3'h4;
   localparam int FC_LGET_TAG_LO = 16;
   localparam int ST_SENSE_BUSY = 0;
   localparam int ST_SENSE_OFF = 1;
   localparam int ST_NEW_BUSY = 2;
   localparam int ST_NEW_OFF = 3;

   // Page select codes
   localparam logic [1:0] PAGE_BAD = 2'h3;

   // Reset values
   localparam logic [ADDR_W-1:0] RST_FP = 16'h0000;
   localparam logic [ADDR_W-1:0] RST_SP = 16'h0000;
   localparam logic [CNT_W-1:0] RST_CNT = 14'h0000;

   typedef enum logic [1:0] {BUS_INSTR, BUS_PAGER, BUS_SEQ} pps_bus_t;
   typedef pps_bus_t [NPAGES-1:0] pps_page_map_t;
   localparam pps_bus_t RST_BUS = BUS_INSTR;

   typedef enum logic [2:0] {
      ST_FETCH, ST_FWAIT, ST_EXEC, ST_RD, ST_RDW, ST_WR, ST_WRW, ST_FC
   } pps_state_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pps_mem_req_t;

   typedef struct packed {
      logic req;
      logic [FC_W-1:0] code;
   } pps_fc_req_t;

   typedef struct packed {
      logic valid;
      logic own;
      logic [FC_W-1:0] code;
   } pps_fc_acc_t;

   typedef struct packed {
      logic [1:0] kind;
      logic [CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [FC_W-1:0] code;
   } pps_instr_t;

   function automatic logic pps_is_state(input logic [FC_W-1:0] code);
      return code[FC_HI:FC_STATE_TAG_LO] == FC_STATE_TAG;
   endfunction

   function automatic logic pps_is_lget(input logic [FC_W-1:0] code);
      return code[FC_HI:FC_LGET_TAG_LO] == FC_LGET_TAG;
   endfunction
endpackage

// ---- rtl/pps_dec.sv ----
`timescale 1ns/1ps
module pps_dec
   import pps_pkg::*;
(
   // Instruction word
   input wire logic [DATA_W-1:0] instr_i,
   output pps_instr_t ins_o,
   // Accepted function code
   input wire logic [FC_W-1:0] code_i,
   output logic is_state_o,
   output logic is_lget_o
);
   assign ins_o.kind = instr_i[TYPE_HI:TYPE_LO];
   assign ins_o.cnt = instr_i[CNT_HI:CNT_LO];
   assign ins_o.addr = instr_i[ADDR_HI:ADDR_LO];
   assign ins_o.code = instr_i[FC_HI:FC_LO];
   assign is_state_o = pps_is_state(code_i);
   assign is_lget_o = pps_is_lget(code_i);
endmodule

// ---- verification/pps_mem_model.sv ----
`timescale 1ns/1ps
module pps_mem_model
   import pps_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Pager bus
   input wire pps_mem_req_t mem_i,
   output logic mem_ack_o,
   output logic [DATA_W-1:0] mem_rdata_o,
   // Function-code arbitration
   input wire pps_fc_req_t fc_i,
   input wire logic ext_req_i,
   input wire logic [FC_W-1:0] ext_code_i,
   input wire logic sense_i,
   input wire logic [7:0] dly_i,
   output pps_fc_acc_t acc_o,
   output logic acc_sense_o
);
   logic [DATA_W-1:0] m [0:1023];
   logic [DATA_W-1:0] rd_r = 32'h0;
   logic [FC_W-1:0] last_code = 19'h0;
   logic [FC_W-1:0] prev_code = 19'h0;
   logic s_r = 1'b0;
   logic md_r, fd_r;
   logic [7:0] mc_r, fc_r;
   int own_cnt = 0;
   // Lines outside an answer show the inverse of the last value
   assign mem_rdata_o = mem_ack_o ? rd_r : ~rd_r;
   assign acc_sense_o = acc_o.valid ? s_r : ~s_r;
   task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      m[a[9:0]] = d;
   endtask
   always @(posedge clk_i) begin
      mem_ack_o <= 1'b0;
      acc_o <= '0;
      if (srst_i) begin
         md_r <= 1'b0;
         fd_r <= 1'b0;
         mc_r <= 8'h0;
         fc_r <= 8'h0;
      end else begin
         if (!mem_i.req) begin
            md_r <= 1'b0;
            mc_r <= 8'h0;
         end else if (!md_r && mc_r >= dly_i) begin
            mem_ack_o <= 1'b1;
            md_r <= 1'b1;
            rd_r <= m[mem_i.addr[9:0]];
            if (mem_i.we) begin
               m[mem_i.addr[9:0]] <= mem_i.wdata;
            end
         end else if (!md_r) begin
            mc_r <= mc_r + 8'h1;
         end
         if (!fc_i.req) begin
            fd_r <= 1'b0;
            fc_r <= 8'h0;
         end
         // One code per cycle, other requesters first
         if (ext_req_i) begin
            acc_o <= '{1'b1, 1'b0, ext_code_i};
         end else if (fc_i.req && !fd_r && fc_r >= dly_i) begin
            acc_o <= '{1'b1, 1'b1, fc_i.code};
            s_r <= sense_i;
            fd_r <= 1'b1;
            last_code <= fc_i.code;
            prev_code <= last_code;
            own_cnt++;
         end else if (fc_i.req && !fd_r) begin
            fc_r <= fc_r + 8'h1;
         end
      end
   end
endmodule

// ---- verification/test_program_pager_sequencer.sv ----
`timescale 1ns/1ps
module test_program_pager_sequencer
   import pps_pkg::*;
();
   logic clk = 1'b0, srst = 1'b1, ce = 1'b1, oper = 1'b1, sw_v = 1'b0;
   logic ext_r = 1'b0, sense = 1'b0, ack, accs, psense, busy;
   logic [1:0] sw_p = 2'h0;
   pps_bus_t sw_b = BUS_INSTR;
   logic [FC_W-1:0] ext_c = 19'h0;
   logic [7:0] dly = 8'h0;
   logic [ADDR_W-1:0] fp, sp;
   logic [DATA_W-1:0] rdata;
   pps_mem_req_t mem;
   pps_fc_req_t fc;
   pps_fc_acc_t acc;
   pps_page_map_t pmap;
   int failures = 0, checked = 0;

   always #2 clk = ~clk;

   pps_pager uut (.clk_i(clk), .srst_i(srst), .ce_i(ce), .operative_i(oper), .busy_o(busy),
      .fetch_ptr_o(fp), .store_ptr_o(sp), .mem_o(mem), .mem_ack_i(ack), .mem_rdata_i(rdata),
      .fc_o(fc), .acc_i(acc), .acc_sense_i(accs), .acc_sense_o(psense), .sw_valid_i(sw_v),
      .sw_page_i(sw_p), .sw_bus_i(sw_b), .page_bus_o(pmap));
   pps_mem_model mdl (.clk_i(clk), .srst_i(srst), .mem_i(mem), .mem_ack_o(ack),
      .mem_rdata_o(rdata), .fc_i(fc), .ext_req_i(ext_r), .ext_code_i(ext_c),
      .sense_i(sense), .dly_i(dly), .acc_o(acc), .acc_sense_o(accs));

   task automatic end_of_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic ext(input logic [FC_W-1:0] c);
      @(posedge clk);
      ext_r <= 1'b1;
      ext_c <= c;
      @(posedge clk);
      ext_r <= 1'b0;
   endtask

   task automatic wait_busy(input logic v, input int n);
      for (int i = 0; i < n && busy !== v; i++) @(posedge clk);
      if (busy !== v) begin
         failures++;
         $display("[FAIL] %0t busy wait timed out", $time);
         end_of_test();
      end
   endtask

   task automatic run(input logic [ADDR_W-1:0] a);
      ext({3'h4, a});
      wait_busy(1'b1, 8);
      wait_busy(1'b0, 3000);
   endtask

   task automatic t_reset;
      chk(32'(busy), 32'h0, "busy after reset");
      chk(32'(fp), 32'h0, "fetch pointer after reset");
      chk(32'(mem.req), 32'h0, "memory request after reset");
      chk(32'(pmap), 32'({BUS_INSTR, BUS_INSTR, BUS_INSTR}), "page map after reset");
   endtask

   task automatic t_switch;
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 3; b++) begin
            @(posedge clk);
            sw_v <= 1'b1;
            sw_p <= 2'(p);
            sw_b <= pps_bus_t'(b);
            @(posedge clk);
            sw_v <= 1'b0;
            @(posedge clk);
            if (p < 3) chk(32'(pmap[p]), 32'(b), "page bus");
         end
      end
      chk(32'(pmap), 32'({BUS_SEQ, BUS_SEQ, BUS_SEQ}), "page code 11 ignored");
      @(posedge clk);
      ce <= 1'b0;
      sw_v <= 1'b1;
      sw_p <= 2'h0;
      sw_b <= BUS_PAGER;
      @(posedge clk);
      ce <= 1'b1;
      sw_v <= 1'b0;
      @(posedge clk);
      chk(32'(pmap[0]), 32'(BUS_SEQ), "enable low freezes page map");
   endtask

   task automatic t_move;
      mdl.put(16'h0010, 32'h4000_0100);
      mdl.put(16'h0011, 32'h8002_0000);
      mdl.put(16'h0012, 32'h0000_8000);
      mdl.put(16'h0013, 32'h4000_0abc);
      mdl.put(16'h0014, 32'hc001_0200);
      mdl.put(16'h0015, 32'h0000_8001);
      mdl.put(16'h0016, 32'h0004_0030);
      mdl.put(16'h0030, 32'h0000_8005);
      mdl.put(16'h0031, 32'h0000_8000);
      mdl.put(16'h0032, 32'h0000_8001);
      run(16'h0010);
      chk(32'(fp), 32'h34, "fetch pointer after halt and skip");
      chk(32'(sp), 32'h201, "store pointer after moves");
      chk(mdl.m[10'h100], 32'h0000_8000, "first moved word");
      chk(mdl.m[10'h101], 32'h4000_0abc, "second moved word");
      chk(mdl.m[10'h200], 32'h0000_8001, "load and move word");
   endtask

   task automatic t_fc;
      int n;
      n = mdl.own_cnt;
      dly <= 8'h3;
      sense <= 1'b1;
      mdl.put(16'h0040, 32'h0001_2345);
      mdl.put(16'h0041, 32'h0000_8000);
      mdl.put(16'h0042, 32'h0000_8000);
      run(16'h0040);
      chk(32'(fp), 32'h43, "sense one skips");
      chk(32'(mdl.prev_code), 32'h12345, "issued code");
      chk(32'(mdl.last_code), 32'h08000, "halt code issued");
      chk(32'(mdl.own_cnt), 32'(n + 2), "code and halt issued");
      sense <= 1'b0;
      run(16'h0040);
      chk(32'(fp), 32'h42, "sense zero steps");
   endtask

   task automatic t_drop;
      int n;
      n = mdl.own_cnt;
      dly <= 8'h28;
      mdl.put(16'h0050, 32'h0001_2345);
      mdl.put(16'h0051, 32'h0000_8000);
      mdl.put(16'h0060, 32'h0000_8000);
      ext({3'h4, 16'h0050});
      for (int i = 0; i < 100 && fc.req !== 1'b1; i++) @(posedge clk);
      if (fc.req !== 1'b1) begin
         failures++;
         $display("[FAIL] %0t code request wait timed out", $time);
         end_of_test();
      end
      ext({3'h4, 16'h0060});
      wait_busy(1'b0, 200);
      chk(32'(fp), 32'h61, "redirect while code pending");
      chk(32'(mdl.own_cnt), 32'(n + 1), "pending code dropped");
      dly <= 8'h0;
   endtask

   task automatic t_state;
      logic [ADDR_W-1:0] f0;
      mdl.put(16'h0070, 32'h8040_0000);
      for (int i = 1; i <= 64; i++) mdl.put(16'(16'h0070 + i), 32'(i));
      ext({3'h4, 16'h0070});
      wait_busy(1'b1, 8);
      repeat (20) @(posedge clk);
      ext(19'h08005);
      repeat (2) @(posedge clk);
      chk(32'(psense), 32'h1, "sense busy");
      chk(32'(busy), 32'h1, "still busy");
      ext(19'h08000);
      wait_busy(1'b0, 8);
      ext(19'h08006);
      repeat (2) @(posedge clk);
      chk(32'(psense), 32'h1, "sense off");
      ext(19'h0800c);
      wait_busy(1'b1, 8);
      ext(19'h08000);
      wait_busy(1'b0, 8);
      oper <= 1'b0;
      repeat (4) @(posedge clk);
      f0 = fp;
      ext({3'h4, 16'h0010});
      repeat (8) @(posedge clk);
      chk(32'(busy), 32'h0, "inoperative stays off");
      chk(32'(fp), 32'(f0), "inoperative keeps pointer");
      ext(19'h0800c);
      repeat (4) @(posedge clk);
      chk(32'(busy), 32'h0, "inoperative start ignored");
      oper <= 1'b1;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_switch();
      t_move();
      t_fc();
      t_drop();
      t_state();
      end_of_test();
   end
endmodule
